// ===== common/aus_pkg.sv
// Constants and carrier types of the audio upsampler serial ports
// What this block does
// - Internal power-on reset initialises the block
// - Operational only 400ms after reset release
// - One master clock; outputs on 48kHz multiples
// - Input port is always clock slave
// - PCM uses word clock, bit clock, line0
// - DSD: bit clock, line0 left, line1 right
// - Register format field ORed with select pin
// - Select pin high DSD, low PCM/DoP
// - Detect DoP and extract embedded DSD
// - Master mode generates output clocks internally
// - Bit clock 32x frame, frame 8x rate
// - Per channel positive and negative data lines
// - Mono-framed 32-bit two's complement MSB first
// - Output sample rate fixed at 384kHz
// - Input words processed as 32 bits
// - Data-valid pin high mutes outputs
// - Soft mute and input rate sensing
// - Role pin low master, high slave
// - Format pin low one-slot DSP frame sync pulse, high right-justified
// - Reset or unlocked holds data, bit clock and frame sync outputs low
`default_nettype none

package aus_pkg;

	// ==========================================================
	// Timing
	localparam int REF_CLK_HZ        = 25000000;
	localparam int MCLK_NOMINAL_HZ   = 24576000;
	localparam int FS_BASE_HZ        = 48000;
	localparam int FS_OUT_HZ         = 8 * FS_BASE_HZ;
	localparam int FRAME_SYNC_PER_FS      = 8;
	localparam int BITS_PER_FRAME    = 32;
	localparam int BIT_RATE_HZ       = FS_OUT_HZ * FRAME_SYNC_PER_FS * BITS_PER_FRAME;
	localparam int HALF_RAW          = REF_CLK_HZ / (2 * BIT_RATE_HZ);
	// Bit rate exceeds what this clock can make; fastest toggle is used
	localparam int BCLK_HALF_CYCLES  = (HALF_RAW < 1) ? 1 : HALF_RAW;
	localparam int READY_DELAY_MS    = 400;
	localparam int READY_CYCLES      = READY_DELAY_MS * (REF_CLK_HZ / 1000);
	localparam int RESET_MIN_NS      = 500;
	localparam int RESET_MIN_CYCLES  = (RESET_MIN_NS * (REF_CLK_HZ / 1000000) + 999) / 1000;
	localparam int PCM_MIN_FS_HZ     = 32000;
	localparam int PCM_MAX_FS_HZ     = 384000;
	localparam int LOCK_TIMEOUT      = 2 * (REF_CLK_HZ / PCM_MIN_FS_HZ);

	// ==========================================================
	// Register map
	localparam int ADDR_W            = 3;
	localparam int DATA_W            = 8;
	localparam logic [2:0] ADDR_CTRL   = 3'h0;
	localparam logic [2:0] ADDR_STATUS = 3'h1;
	localparam logic [2:0] ADDR_PER_LO = 3'h2;
	localparam logic [2:0] ADDR_PER_HI = 3'h3;
	localparam int CTRL_FMT_LSB      = 0;
	localparam int CTRL_MUTE_BIT     = 2;
	localparam int CTRL_PHASE_BIT    = 3;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int STAT_LOCK_BIT     = 0;
	localparam int STAT_DOP_BIT      = 1;
	localparam int STAT_DSD_BIT      = 2;
	localparam int STAT_READY_BIT    = 3;

	// ==========================================================
	// Stream constants
	localparam logic [7:0] DOP_MARK_A = 8'h05;
	localparam logic [7:0] DOP_MARK_B = 8'hfa;
	localparam logic [4:0] RJ_FRAME_SYNC_SLOT = 5'h10;

	typedef enum {AUS_LK_WAIT, AUS_LK_HUNT, AUS_LK_LOCKED} aus_lock_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} aus_bus_s;

	typedef struct packed {
		logic data_pos;
		logic data_neg;
		logic bclk_out;
		logic bclk_oe_n;
		logic frame_sync_out;
		logic frame_sync_oe_n;
	} aus_port_s;

endpackage

`default_nettype wire

// ===== rtl/aus_serial_ports.sv
// Serial input port, lock control and two mono-framed output ports
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`default_nettype none

module aus_serial_ports #(
	parameter int READY_CYCLES = aus_pkg::READY_CYCLES
) (
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst,
	input  wire logic                reset_n_pin,
	// Input port, always slave
	input  wire logic                input_word_clock,
	input  wire logic                input_bit_clock,
	input  wire logic                input_data_line0,
	input  wire logic                input_data_line1,
	// Mode pins
	input  wire logic                dsd_select_pin,
	input  wire logic                output_format_pin,
	input  wire logic                output_clock_role_pin,
	input  wire logic                data_valid_pin,
	// Output port clocks in slave role
	input  wire logic                left_out_bit_clock,
	input  wire logic                left_out_frame_sync,
	input  wire logic                right_out_bit_clock,
	input  wire logic                right_out_frame_sync,
	// Register port
	input  wire aus_pkg::aus_bus_s   bus,
	output var  logic [7:0]          rdata,
	// Output ports
	output var  aus_pkg::aus_port_s  left_out,
	output var  aus_pkg::aus_port_s  right_out
);

	// ==========================================================
	// Pin sampling and internal reset
	logic       srst;
	logic [3:0] pin_q;
	logic [3:0] pin_q2;
	logic [3:0] mode_q;
	logic       rpin_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_q  <= 4'h0;
			pin_q2 <= 4'h0;
			mode_q <= 4'h1;
			rpin_q <= 1'b0;
		end else begin
			pin_q  <= {input_data_line1, input_data_line0, input_bit_clock, input_word_clock};
			pin_q2 <= pin_q;
			mode_q <= {data_valid_pin, output_clock_role_pin, output_format_pin, dsd_select_pin};
			rpin_q <= reset_n_pin;
		end
	end

	// Power-on comes through rst; the pin adds a synchronous reset
	assign srst = ~rpin_q;

	wire ws_now    = pin_q[0];
	wire bck_rise  = pin_q[1] & ~pin_q2[1];
	wire ws_edge   = pin_q[0] ^ pin_q2[0];
	wire d0        = pin_q[2];
	wire d1        = pin_q[3];
	wire fmt_pin   = mode_q[0];
	wire fmt_out   = mode_q[1];
	wire slave     = mode_q[2];
	wire invalid   = mode_q[3];

	// ==========================================================
	// Registers
	logic [7:0]  ctrl_reg;
	logic [7:0]  rdata_reg;
	logic [15:0] period_reg;
	logic        dop_reg;
	aus_pkg::aus_lock_e lock_reg;
	logic        ready_reg;

	wire dsd_mode  = fmt_pin | ctrl_reg[aus_pkg::CTRL_FMT_LSB];
	wire soft_mute = ctrl_reg[aus_pkg::CTRL_MUTE_BIT];
	wire phase_inv = ctrl_reg[aus_pkg::CTRL_PHASE_BIT];
	wire locked    = (lock_reg == aus_pkg::AUS_LK_LOCKED);

	wire [7:0] status_w =
		(8'(locked) << aus_pkg::STAT_LOCK_BIT) | (8'(dop_reg) << aus_pkg::STAT_DOP_BIT) |
		(8'(dsd_mode) << aus_pkg::STAT_DSD_BIT) | (8'(ready_reg) << aus_pkg::STAT_READY_BIT);

	wire [7:0] rd_sel =
		(bus.addr == aus_pkg::ADDR_CTRL)   ? ctrl_reg :
		(bus.addr == aus_pkg::ADDR_STATUS) ? status_w :
		(bus.addr == aus_pkg::ADDR_PER_LO) ? period_reg[7:0] :
		(bus.addr == aus_pkg::ADDR_PER_HI) ? period_reg[15:8] : 8'h00;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg  <= aus_pkg::CTRL_RESET;
			rdata_reg <= 8'h00;
		end else begin
			if (srst) begin
				ctrl_reg <= aus_pkg::CTRL_RESET;
			end else if (bus.wr && bus.addr == aus_pkg::ADDR_CTRL) begin
				ctrl_reg <= bus.wdata;
			end
			rdata_reg <= bus.rd ? rd_sel : 8'h00;
		end
	end
	assign rdata = rdata_reg;

	// ==========================================================
	// Input capture: I2S words land left-justified in 32 bits
	logic [31:0] acc_reg;
	logic [5:0]  cnt_reg;
	logic        ws_last_reg;
	logic [31:0] dsd_l_reg;
	logic [31:0] dsd_r_reg;
	logic [4:0]  dsd_cnt_reg;
	logic [31:0] hold_reg [2];
	logic        fresh_reg;
	logic        prev_mark_reg;

	wire [31:0] bit_mask = (cnt_reg < 6'd32) ? (32'h80000000 >> cnt_reg) : 32'h0;
	wire [31:0] acc_ins  = acc_reg | (bit_mask & {32{d0}});
	wire        pcm_done = ~dsd_mode & bck_rise & (ws_now != ws_last_reg);
	wire        dsd_done = dsd_mode & bck_rise & (dsd_cnt_reg == 5'h1f);
	wire        mark_now = (acc_ins[31:24] == aus_pkg::DOP_MARK_A) |
	                       (acc_ins[31:24] == aus_pkg::DOP_MARK_B);
	wire [31:0] dop_word = {acc_ins[23:8], 16'h0000};
	wire [31:0] pcm_word = (dop_reg & mark_now) ? dop_word : acc_ins;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			acc_reg       <= 32'h0;
			cnt_reg       <= 6'h0;
			ws_last_reg   <= 1'b0;
			dsd_l_reg     <= 32'h0;
			dsd_r_reg     <= 32'h0;
			dsd_cnt_reg   <= 5'h0;
			hold_reg[0]   <= 32'h0;
			hold_reg[1]   <= 32'h0;
			fresh_reg     <= 1'b0;
			dop_reg       <= 1'b0;
			prev_mark_reg <= 1'b0;
		end else if (srst) begin
			acc_reg     <= 32'h0;
			cnt_reg     <= 6'h0;
			dsd_cnt_reg <= 5'h0;
			fresh_reg   <= 1'b0;
			dop_reg     <= 1'b0;
		end else begin
			if (bck_rise & ~dsd_mode) begin
				ws_last_reg <= ws_now;
				// Word clock flips one bit ahead of the MSB, so this is the LSB
				if (pcm_done) begin
					acc_reg  <= 32'h0;
					cnt_reg  <= 6'h0;
					hold_reg[ws_last_reg] <= pcm_word;
					prev_mark_reg <= mark_now;
					dop_reg  <= mark_now & prev_mark_reg;
				end else begin
					acc_reg <= acc_ins;
					cnt_reg <= (cnt_reg < 6'd32) ? cnt_reg + 6'd1 : cnt_reg;
				end
			end
			if (bck_rise & dsd_mode) begin
				dsd_l_reg   <= {dsd_l_reg[30:0], d0};
				dsd_r_reg   <= {dsd_r_reg[30:0], d1};
				dsd_cnt_reg <= dsd_cnt_reg + 5'h1;
				dop_reg     <= 1'b0;
			end
			if (dsd_done) begin
				hold_reg[0] <= {dsd_l_reg[30:0], d0};
				hold_reg[1] <= {dsd_r_reg[30:0], d1};
			end
			if (pcm_done | dsd_done) begin
				fresh_reg <= 1'b1;
			end else if (lock_reg != aus_pkg::AUS_LK_LOCKED & invalid) begin
				fresh_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Rate sensing, activity watch, readiness and lock
	logic [15:0] meas_reg;
	logic [15:0] idle_reg;
	logic [23:0] ready_cnt_reg;

	wire activity = dsd_mode ? bck_rise : ws_edge;
	wire ws_rise  = ws_edge & ws_now & ~dsd_mode;
	wire stale    = (idle_reg >= 16'(aus_pkg::LOCK_TIMEOUT));
	wire ready_hit = (ready_cnt_reg >= 24'(READY_CYCLES - 1));

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			meas_reg      <= 16'h0;
			period_reg    <= 16'h0;
			idle_reg      <= 16'h0;
			ready_cnt_reg <= 24'h0;
			ready_reg     <= 1'b0;
			lock_reg      <= aus_pkg::AUS_LK_WAIT;
		end else if (srst) begin
			ready_cnt_reg <= 24'h0;
			ready_reg     <= 1'b0;
			lock_reg      <= aus_pkg::AUS_LK_WAIT;
		end else begin
			meas_reg <= ws_rise ? 16'h0 : (meas_reg == 16'hffff ? meas_reg : meas_reg + 16'h1);
			if (ws_rise) begin
				period_reg <= meas_reg + 16'h1;
			end
			idle_reg <= activity ? 16'h0 : (stale ? idle_reg : idle_reg + 16'h1);
			unique case (lock_reg)
				aus_pkg::AUS_LK_WAIT: begin
					ready_cnt_reg <= ready_cnt_reg + 24'h1;
					if (ready_hit) begin
						ready_reg <= 1'b1;
						lock_reg  <= aus_pkg::AUS_LK_HUNT;
					end
				end
				aus_pkg::AUS_LK_HUNT: begin
					if (~invalid & ~stale & fresh_reg) begin
						lock_reg <= aus_pkg::AUS_LK_LOCKED;
					end
				end
				aus_pkg::AUS_LK_LOCKED: begin
					if (invalid | stale) begin
						lock_reg <= aus_pkg::AUS_LK_HUNT;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Master timing from the single reference clock
	logic [7:0] div_reg;
	logic       mbclk_reg;
	logic [4:0] mslot_reg;

	wire tick  = (div_reg == 8'(aus_pkg::BCLK_HALF_CYCLES - 1));
	wire mfall = tick & mbclk_reg;

	function automatic logic frame_sync_of(input logic [4:0] slot, input logic rj);
		frame_sync_of = rj ? (slot >= aus_pkg::RJ_FRAME_SYNC_SLOT) : (slot == 5'h0);
	endfunction

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_reg   <= 8'h0;
			mbclk_reg <= 1'b0;
			mslot_reg <= 5'h1f;
		end else if (~locked) begin
			div_reg   <= 8'h0;
			mbclk_reg <= 1'b0;
			mslot_reg <= 5'h1f;
		end else begin
			div_reg <= tick ? 8'h0 : div_reg + 8'h1;
			if (tick) begin
				mbclk_reg <= ~mbclk_reg;
			end
			if (mfall) begin
				mslot_reg <= mslot_reg + 5'h1;
			end
		end
	end

	// ==========================================================
	// Output ports, one per channel
	aus_pkg::aus_port_s port_reg [2];
	wire [1:0] ext_bclk  = {right_out_bit_clock, left_out_bit_clock};
	wire [1:0] ext_frame_sync = {right_out_frame_sync, left_out_frame_sync};

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_port
			logic        sb_q;
			logic        sb_q2;
			logic        sf_q;
			logic        sf_last;
			logic [4:0]  sslot_reg;
			logic [31:0] sh_reg;
			aus_pkg::aus_port_s port_next;

			wire sfall      = ~sb_q & sb_q2;
			wire sframe     = sf_q & ~sf_last;
			wire [4:0] snext = sframe ? 5'h0 : sslot_reg + 5'h1;
			wire adv        = slave ? sfall : mfall;
			wire [4:0] slot = slave ? snext : mslot_reg + 5'h1;
			// Mute acts only at frame start so a word is never cut short
			wire [31:0] word = soft_mute ? 32'h0 :
			                   (phase_inv ? ~hold_reg[ch] : hold_reg[ch]);
			wire [31:0] sh_next = ~adv ? sh_reg :
			                      (slot == 5'h0) ? word : {sh_reg[30:0], 1'b0};

			always_comb begin
				port_next.data_pos   = locked & sh_next[31];
				port_next.data_neg   = locked & ~sh_next[31];
				port_next.bclk_out   = locked & ~slave & (tick ? ~mbclk_reg : mbclk_reg);
				port_next.frame_sync_out  = locked & ~slave &
				                       frame_sync_of(mfall ? slot : mslot_reg, fmt_out);
				port_next.bclk_oe_n  = slave;
				port_next.frame_sync_oe_n = slave;
			end

			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					sb_q        <= 1'b0;
					sb_q2       <= 1'b0;
					sf_q        <= 1'b0;
					sf_last     <= 1'b0;
					sslot_reg   <= 5'h0;
					sh_reg      <= 32'h0;
					port_reg[ch] <= '0;
				end else begin
					sb_q    <= ext_bclk[ch];
					sb_q2   <= sb_q;
					sf_q    <= ext_frame_sync[ch];
					if (sfall) begin
						sf_last   <= sf_q;
						sslot_reg <= snext;
					end
					sh_reg       <= locked ? sh_next : 32'h0;
					port_reg[ch] <= port_next;
				end
			end

			neg_mirror_a: assert property (@(posedge ref_clk) disable iff (rst)
				locked |=> (port_reg[ch].data_neg == (~port_reg[ch].data_pos & $past(locked))))
				else $error("negative line not the complement");
			slave_release_a: assert property (@(posedge ref_clk) disable iff (rst)
				slave |=> port_reg[ch].bclk_oe_n && port_reg[ch].frame_sync_oe_n)
				else $error("slave port still drives clocks");
		end
	endgenerate

	assign left_out  = port_reg[0];
	assign right_out = port_reg[1];

	// ==========================================================
	// Checks
	sequence unlocked_s;
		!locked ##1 !locked;
	endsequence

	hard_mute_a: assert property (@(posedge ref_clk) disable iff (rst)
		unlocked_s |-> !left_out.data_pos && !left_out.bclk_out && !right_out.frame_sync_out)
		else $error("output pins not low while unlocked");
	valid_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
		locked && mode_q[3] |=> !locked)
		else $error("data-valid high did not unlock");
	ready_first_a: assert property (@(posedge ref_clk) disable iff (rst)
		locked |-> ready_reg)
		else $error("locked before ready delay");
	dsd_or_a: assert property (@(posedge ref_clk) disable iff (rst)
		mode_q[0] |-> dsd_mode)
		else $error("select pin did not force DSD");
	dop_pcm_a: assert property (@(posedge ref_clk) disable iff (rst)
		dsd_mode && bck_rise |=> !dop_reg)
		else $error("DoP flag set in DSD mode");
	frame_sync_a: assert property (@(posedge ref_clk) disable iff (rst)
		locked && !slave && !fmt_out && mfall && mslot_reg == 5'h1f |=> left_out.frame_sync_out)
		else $error("frame sync missing at slot zero");
	master_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
		!slave ##1 !slave |-> !left_out.bclk_oe_n && !right_out.frame_sync_oe_n)
		else $error("master port not driving clocks");
	hold_write_a: assert property (@(posedge ref_clk) disable iff (rst || srst)
		pcm_done |=> hold_reg[$past(ws_last_reg)] == $past(pcm_word))
		else $error("input word not held");

endmodule // aus_serial_ports

`default_nettype wire

// ===== tb/aus_rx_source.sv
// Behavioural I2S source standing in for the digital audio receiver
`default_nettype none

module aus_rx_source (
	// Clock
	input  wire logic        ref_clk,
	// Stream control
	input  wire logic        enable,
	input  wire logic [31:0] left_word,
	input  wire logic [31:0] right_word,
	// Serial lines
	output var  logic        word_clock,
	output var  logic        bit_clock,
	output var  logic        data0,
	output var  logic        data1
);
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// Frame generator
	initial begin
		logic [63:0] frame;
		word_clock = 1'b0;
		bit_clock  = 1'b0;
		data0      = 1'b0;
		data1      = 1'b1;
		forever begin
			@(posedge ref_clk);
			if (!enable) begin
				// Clock stands still; undriven lines must not look stable
				data0 <= ~data0;
				data1 <= ~data1;
			end else begin
				frame = {left_word, right_word};
				for (int i = 63; i >= 0; i--) begin
					bit_clock  <= 1'b0;
					// Word select moves one bit ahead of each MSB
					word_clock <= (i <= 32) && (i != 0);
					data0      <= frame[i];
					data1      <= ~frame[i];
					repeat (2) @(posedge ref_clk);
					bit_clock <= 1'b1;
					repeat (2) @(posedge ref_clk);
				end
			end
		end
	end
endmodule // aus_rx_source

`default_nettype wire

// ===== tb/tb_aus_serial_ports.sv
// Self-checking bench of the serial ports with scoreboard queues
`default_nettype none

module tb_aus_serial_ports;
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// Signals
	logic               ref_clk, rst, reset_n_pin, fmt_pin, role_pin, valid_pin;
	logic               dsd_pin, sbclk, sfs, src_en, wclk, bclk, d0, d1;
	logic               rd_seen = 1'b0;
	logic [31:0]        lw, rw, sl, sr;
	logic [7:0]         rdata;
	logic [7:0]         last_rd = 8'h00;
	logic [15:0]        n;
	logic [32:0]        e;
	aus_pkg::aus_bus_s  bus;
	aus_pkg::aus_port_s left_out, right_out;
	aus_pkg::aus_port_s p [2];
	logic               pb [2] = '{1'b0, 1'b0};
	logic               pf [2] = '{1'b0, 1'b0};
	logic [31:0]        sp [2], sn [2];
	int                 cnt [2] = '{-1, -1};
	int                 fo [2] = '{0, 0};
	logic [15:0]        rq [$];
	logic [32:0]        qw [2][$];
	int                 fail_count, tests_run, seed, i;

	assign p[0] = left_out;
	assign p[1] = right_out;

	aus_serial_ports #(.READY_CYCLES(20)) dut_u (
		.ref_clk(ref_clk), .rst(rst), .reset_n_pin(reset_n_pin),
		.input_word_clock(wclk), .input_bit_clock(bclk),
		.input_data_line0(d0), .input_data_line1(d1),
		.dsd_select_pin(dsd_pin), .output_format_pin(fmt_pin),
		.output_clock_role_pin(role_pin), .data_valid_pin(valid_pin),
		.left_out_bit_clock(sbclk), .left_out_frame_sync(sfs),
		.right_out_bit_clock(sbclk), .right_out_frame_sync(sfs),
		.bus(bus), .rdata(rdata), .left_out(left_out), .right_out(right_out)
	);

	aus_rx_source src_u (
		.ref_clk(ref_clk), .enable(src_en), .left_word(lw), .right_word(rw),
		.word_clock(wclk), .bit_clock(bclk), .data0(d0), .data1(d1)
	);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// ==========================================================
	// Tasks
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
		tests_run++;
		if (got !== ex) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus <= '0;
	endtask

	// Mask of zero makes a plain poll without a comparison
	task automatic rd_reg(input logic [2:0] a, input logic [7:0] m, input logic [7:0] ex);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		rq.push_back({m, ex});
		@(posedge ref_clk);
		bus <= '0;
	endtask

	task automatic drain(input string nm);
		int k;
		for (k = 0; k < 4000 && qw[0].size() + qw[1].size() > 0; k++) @(posedge ref_clk);
		if (k == 4000) begin
			fail_count++;
			$display("mismatch %s expected 0 seen %0d", nm, qw[0].size());
			summarize();
		end
		$display("test %s done", nm);
	endtask

	task automatic expect_words(input logic neg, input logic [31:0] a, input logic [31:0] b);
		repeat (600) @(posedge ref_clk);
		qw[0].push_back({neg, a});
		qw[1].push_back({neg, b});
		qw[0].push_back({neg, a});
		qw[1].push_back({neg, b});
	endtask

	// ==========================================================
	// Monitors
	always @(posedge ref_clk) begin
		if (rd_seen) begin
			last_rd = rdata;
			if (rq.size() > 0) begin
				n = rq.pop_front();
				if (n[15:8] != 8'h00) check("rdata", 32'(n[7:0]), 32'(rdata & n[15:8]));
			end
		end
		rd_seen = bus.rd;
	end

	always @(posedge ref_clk) begin
		for (int c = 0; c < 2; c++) begin
			if (p[c].bclk_out && !pb[c]) begin
				if (fmt_pin ? (!p[c].frame_sync_out && pf[c]) : (p[c].frame_sync_out && !pf[c])) begin
					cnt[c] = 0;
					fo[c] = 0;
				end
				if (cnt[c] >= 0) begin
					sp[c] = {sp[c][30:0], p[c].data_pos};
					sn[c] = {sn[c][30:0], p[c].data_neg};
					fo[c] += int'(p[c].frame_sync_out);
					cnt[c]++;
					if (cnt[c] == 32 && qw[c].size() > 0) begin
						e = qw[c].pop_front();
						check("data_pos", e[31:0], sp[c]);
						if (e[32]) check("data_neg", ~e[31:0], sn[c]);
						check("frame_sync_slots", fmt_pin ? 32'd16 : 32'd1, 32'(fo[c]));
					end
					if (cnt[c] == 32) cnt[c] = -1;
				end
				pf[c] = p[c].frame_sync_out;
			end
			pb[c] = p[c].bclk_out;
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		rst = 1'b1; reset_n_pin = 1'b1; fmt_pin = 1'b0; role_pin = 1'b0;
		valid_pin = 1'b0; src_en = 1'b0; bus = '0; dsd_pin = 1'b0; sbclk = 1'b0; sfs = 1'b0;
		lw = 32'h0; rw = 32'h0; fail_count = 0; tests_run = 0; seed = 52;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		check("left_out", 32'h0, 32'(left_out));
		check("right_out", 32'h0, 32'(right_out));
		rd_reg(3'h0, 8'hff, 8'h00);
		rd_reg(3'h1, 8'h08, 8'h00);
		repeat (30) @(posedge ref_clk);
		rd_reg(3'h1, 8'h08, 8'h08);
		wr_reg(3'h0, 8'h01);
		rd_reg(3'h1, 8'h04, 8'h04);
		wr_reg(3'h0, 8'h00);
		rd_reg(3'h1, 8'h04, 8'h00);
		wr_reg(3'h7, 8'hff);
		wr_reg(3'h1, 8'hff);
		rd_reg(3'h6, 8'hff, 8'h00);
		rd_reg(3'h0, 8'hff, 8'h00);
		dsd_pin <= 1'b1;
		rd_reg(3'h1, 8'h04, 8'h04);
		dsd_pin <= 1'b0;
		rd_reg(3'h1, 8'h04, 8'h00);
		$display("test registers done");
		lw = {24'($random(seed)), 8'h00};
		rw = {24'($random(seed)), 8'h00};
		src_en <= 1'b1;
		for (i = 0; i < 100 && !last_rd[0]; i++) begin
			rd_reg(3'h1, 8'h00, 8'h00);
			repeat (30) @(posedge ref_clk);
		end
		if (!last_rd[0]) begin
			fail_count++;
			$display("mismatch lock expected 1 seen 0");
			summarize();
		end
		check("bclk_oe_n", 32'h0, 32'(left_out.bclk_oe_n));
		expect_words(1'b1, lw, rw);
		drain("master_dsp");
		fmt_pin <= 1'b1;
		lw = {24'($random(seed)), 8'h00};
		rw = {24'($random(seed)), 8'h00};
		expect_words(1'b1, lw, rw);
		drain("right_justified");
		wr_reg(3'h0, 8'h04);
		expect_words(1'b1, 32'h0, 32'h0);
		drain("soft_mute");
		wr_reg(3'h0, 8'h08);
		expect_words(1'b1, ~lw, ~rw);
		drain("phase_invert");
		wr_reg(3'h0, 8'h00);
		role_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		check("frame_sync_oe_n", 32'h1, 32'(right_out.frame_sync_oe_n));
		// Both ports share one external clock pair; slow enough that data settles before a rise
		for (i = 0; i < 33; i++) begin
			sbclk <= 1'b1;
			if (i > 0) begin
				sl = {sl[30:0], left_out.data_pos};
				sr = {sr[30:0], right_out.data_pos};
			end
			repeat (4) @(posedge ref_clk);
			sbclk <= 1'b0;
			sfs   <= (i == 0);
			repeat (4) @(posedge ref_clk);
		end
		check("slave_left", lw, sl);
		check("slave_right", rw, sr);
		$display("test slave done");
		role_pin <= 1'b0;
		valid_pin <= 1'b1;
		repeat (10) @(posedge ref_clk);
		check("left_out", 32'h0, 32'(left_out));
		check("right_out", 32'h0, 32'(right_out));
		valid_pin <= 1'b0;
		$display("test data_valid done");
		wr_reg(3'h0, 8'h04);
		reset_n_pin <= 1'b0;
		repeat (13) @(posedge ref_clk);
		check("left_out", 32'h0, 32'(left_out));
		reset_n_pin <= 1'b1;
		rd_reg(3'h0, 8'hff, 8'h00);
		repeat (2) @(posedge ref_clk);
		$display("test reset_pin done");
		summarize();
	end
endmodule // tb_aus_serial_ports

`default_nettype wire
